/* common/spm_pkg.sv */
// Overview of operation
// - two-bit serial port 0 select; reset value 00 routes card port zero onto pins 0-5
// - select 01: pins 0-3 audio port zero, pins 4-5 general purpose pins 4-5
// - select 10: all six pins are general purpose pins 0-5 in order
// - select 11: pins 0-5 carry the buffered serial port signals
// - select register bit 15 picks receive clock or source clock on pin 5
// - pull inhibit register one bit n controls pull-down of serial port 0 pin n
// - each address pin select bit: 0 gives address line, 1 gives general purpose pin
// - six select bits cover address 15-20, mapped onto general purpose pins 21-26
// - pull inhibit register two bits 0-5 control address pin pull-downs, any function
package spm_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int SP0_PINS = 6;
	localparam int ADDR_PINS = 6;
	localparam int BSP_PINS = 5;
	localparam int AUDIO_PINS = 4;

	// register addresses
	localparam logic [15:0] EXT_BUS_SELECT_ADDR = 16'h1c00;
	localparam logic [15:0] PULL_INHIBIT_ONE_ADDR = 16'h1c17;
	localparam logic [15:0] PULL_INHIBIT_TWO_ADDR = 16'h1c18;

	// field positions of the external bus select register
	localparam int ADDR_SEL_LSB = 0;
	localparam int SP0_SEL_LSB = 10;
	localparam int BSP_CLK_SEL_BIT = 15;
	// field position of the pull inhibit bits
	localparam int PULL_LSB = 0;

	// reset values
	localparam logic [15:0] EXT_BUS_SELECT_RESET = 16'h0000;
	localparam logic [15:0] PULL_INHIBIT_RESET = 16'h0000;
	localparam logic [15:0] READ_IDLE = 16'h0000;
	localparam logic [5:0] PAD_OUT_RESET = 6'h00;
	localparam logic [5:0] PAD_OE_N_RESET = 6'h3f;

	// serial port 0 functions, in select field order
	typedef enum logic [1:0] {
		SPM_SEL_CARD,
		SPM_SEL_AUDIO,
		SPM_SEL_GP,
		SPM_SEL_BSP
	} spm_sp0_sel_t;
endpackage : spm_pkg

/* rtl/spm_pin_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module spm_pin_mux (
	input wire logic core_clk,
	input wire logic reset,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// serial port 0 pads
	input wire logic [5:0] sp0_pad_in,
	output logic [5:0] sp0_pad_out,
	output logic [5:0] sp0_pad_oe_n,
	output logic [5:0] sp0_pulldown_en,
	// upper address pads
	input wire logic [5:0] addr_pad_in,
	output logic [5:0] addr_pad_out,
	output logic [5:0] addr_pad_oe_n,
	output logic [5:0] addr_pulldown_en,
	// card port zero: bit 0 clock, bit 1 command, bits 5:2 data
	input wire logic [5:0] card_out,
	input wire logic [5:0] card_oe_n,
	output logic [5:0] card_in,
	// audio port zero: clock, frame sync, transmit, receive
	input wire logic [3:0] audio_out,
	input wire logic [3:0] audio_oe_n,
	output logic [3:0] audio_in,
	// buffered serial port: tx clock, tx frame, tx data, rx data, rx frame
	input wire logic [4:0] bsp_out,
	input wire logic [4:0] bsp_oe_n,
	output logic [4:0] bsp_in,
	input wire logic bsp_rx_clk_out,
	input wire logic bsp_rx_clk_oe_n,
	output logic bsp_rx_clk_in,
	output logic bsp_src_clk_in,
	// general purpose pins 0 to 5
	input wire logic [5:0] gp_lo_out,
	input wire logic [5:0] gp_lo_oe_n,
	output logic [5:0] gp_lo_in,
	// general purpose pins 21 to 26
	input wire logic [5:0] gp_hi_out,
	input wire logic [5:0] gp_hi_oe_n,
	output logic [5:0] gp_hi_in,
	// external memory address bits 20:15, output only
	input wire logic [5:0] ext_mem_addr_line
);
	logic [15:0] ext_bus_select_reg;
	logic [15:0] pull_inhibit_reg_one;
	logic [15:0] pull_inhibit_reg_two;
	spm_pkg::spm_sp0_sel_t serial_port0_select;
	logic bsp_clk_sel;
	logic [5:0] addr_pin_select;
	logic [5:0] sp0_out_d;
	logic [5:0] sp0_oe_n_d;
	logic [5:0] card_in_d;
	logic [3:0] audio_in_d;
	logic [5:0] gp_lo_in_d;
	logic [4:0] bsp_in_d;
	logic bsp_rx_clk_in_d;
	logic bsp_src_clk_in_d;
	logic [5:0] addr_out_d;
	logic [5:0] addr_oe_n_d;
	logic [5:0] gp_hi_in_d;

	// per-bit two-way select, used for both data and enables
	function automatic logic [5:0] pick_bits(
		input logic [5:0] sel,
		input logic [5:0] when_zero,
		input logic [5:0] when_one
	);
		pick_bits = (when_zero & ~sel) | (when_one & sel);
	endfunction : pick_bits

	spm_regs u_regs (
		.core_clk(core_clk),
		.reset(reset),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.ext_bus_select_reg(ext_bus_select_reg),
		.pull_inhibit_reg_one(pull_inhibit_reg_one),
		.pull_inhibit_reg_two(pull_inhibit_reg_two)
	);

	// select fields; addr15_pin_select is bit 0, addr20_pin_select bit 5
	assign serial_port0_select = spm_pkg::spm_sp0_sel_t'(
		ext_bus_select_reg[spm_pkg::SP0_SEL_LSB +: 2]);
	assign bsp_clk_sel = ext_bus_select_reg[spm_pkg::BSP_CLK_SEL_BIT];
	assign addr_pin_select = ext_bus_select_reg[spm_pkg::ADDR_SEL_LSB +: 6];

	// a set inhibit bit turns the pull-down off, whatever the function
	assign sp0_pulldown_en = ~pull_inhibit_reg_one[spm_pkg::PULL_LSB +: 6];
	assign addr_pulldown_en = ~pull_inhibit_reg_two[spm_pkg::PULL_LSB +: 6];

	spm_sp0_mux u_sp0_mux (
		.sel(serial_port0_select),
		.bsp_clk_sel(bsp_clk_sel),
		.pad_in(sp0_pad_in),
		.card_out(card_out),
		.card_oe_n(card_oe_n),
		.audio_out(audio_out),
		.audio_oe_n(audio_oe_n),
		.gp_out(gp_lo_out),
		.gp_oe_n(gp_lo_oe_n),
		.bsp_out(bsp_out),
		.bsp_oe_n(bsp_oe_n),
		.bsp_rx_clk_out(bsp_rx_clk_out),
		.bsp_rx_clk_oe_n(bsp_rx_clk_oe_n),
		.pad_out(sp0_out_d),
		.pad_oe_n(sp0_oe_n_d),
		.card_in(card_in_d),
		.audio_in(audio_in_d),
		.gp_in(gp_lo_in_d),
		.bsp_in(bsp_in_d),
		.bsp_rx_clk_in(bsp_rx_clk_in_d),
		.bsp_src_clk_in(bsp_src_clk_in_d)
	);

	// address pins: bit n of the select moves pin n from address n+15 to gp n+21
	// the memory controller always drives, so its enable is a constant low
	assign addr_out_d = pick_bits(addr_pin_select, ext_mem_addr_line, gp_hi_out);
	assign addr_oe_n_d = pick_bits(addr_pin_select, 6'h00, gp_hi_oe_n);
	assign gp_hi_in_d = addr_pad_in & addr_pin_select;

	// pad-side flops: one cycle of latency buys clean glitch-free pad drive
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sp0_pad_out <= spm_pkg::PAD_OUT_RESET;
			sp0_pad_oe_n <= spm_pkg::PAD_OE_N_RESET;
		end else begin
			sp0_pad_out <= sp0_out_d;
			sp0_pad_oe_n <= sp0_oe_n_d;
		end
	end

	// address pad flops
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			addr_pad_out <= spm_pkg::PAD_OUT_RESET;
			addr_pad_oe_n <= spm_pkg::PAD_OE_N_RESET;
		end else begin
			addr_pad_out <= addr_out_d;
			addr_pad_oe_n <= addr_oe_n_d;
		end
	end

	// peripheral-side input flops for serial port 0 functions
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			card_in <= 6'h00;
			audio_in <= 4'h0;
			gp_lo_in <= 6'h00;
			bsp_in <= 5'h00;
			bsp_rx_clk_in <= 1'b0;
			bsp_src_clk_in <= 1'b0;
		end else begin
			card_in <= card_in_d;
			audio_in <= audio_in_d;
			gp_lo_in <= gp_lo_in_d;
			bsp_in <= bsp_in_d;
			bsp_rx_clk_in <= bsp_rx_clk_in_d;
			bsp_src_clk_in <= bsp_src_clk_in_d;
		end
	end

	// upper general purpose inputs; a pin left on the address sees low
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			gp_hi_in <= 6'h00;
		end else begin
			gp_hi_in <= gp_hi_in_d;
		end
	end

	// switching selects mid-transfer glitches the peripheral; software
	// must reset that peripheral afterwards, the mux does not

	// register write and read events
	sequence sel_write_s;
		reg_wr && reg_addr == spm_pkg::EXT_BUS_SELECT_ADDR;
	endsequence
	sequence pull_one_write_s;
		reg_wr && reg_addr == spm_pkg::PULL_INHIBIT_ONE_ADDR;
	endsequence
	sequence pull_two_write_s;
		reg_wr && reg_addr == spm_pkg::PULL_INHIBIT_TWO_ADDR;
	endsequence
	sequence sel_read_s;
		reg_rd && reg_addr == spm_pkg::EXT_BUS_SELECT_ADDR;
	endsequence

	// pad flops still hold reset values after the release edge, so
	// continuous routing checks only start once this goes high
	logic pads_live_q;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pads_live_q <= 1'b0;
		end else begin
			pads_live_q <= 1'b1;
		end
	end

	// a select written to 00 routes the card port two cycles later
	card_route_a: assert property (
		@(posedge core_clk) disable iff (reset)
		sel_write_s ##0 (reg_wdata[11:10] == 2'b00) ##1 !reg_wr[*1] |=>
			sp0_pad_out == $past(card_out) && sp0_pad_oe_n == $past(card_oe_n)
			&& card_in == $past(sp0_pad_in))
		else $error("card port not routed after select 00");

	// audio mode, with pins 4 and 5 on general purpose
	audio_route_a: assert property (
		@(posedge core_clk) disable iff (reset)
		serial_port0_select == spm_pkg::SPM_SEL_AUDIO |=>
			sp0_pad_out == {$past(gp_lo_out[5:4]), $past(audio_out)}
			&& audio_in == $past(sp0_pad_in[3:0])
			&& gp_lo_in == {$past(sp0_pad_in[5:4]), 4'h0})
		else $error("audio mode routing wrong");

	// general purpose mode in pin order
	gp_route_a: assert property (
		@(posedge core_clk) disable iff (reset)
		serial_port0_select == spm_pkg::SPM_SEL_GP |=>
			sp0_pad_out == $past(gp_lo_out) && sp0_pad_oe_n == $past(gp_lo_oe_n)
			&& gp_lo_in == $past(sp0_pad_in))
		else $error("gp mode routing wrong");

	// buffered serial port on pins 0 to 4
	bsp_route_a: assert property (
		@(posedge core_clk) disable iff (reset)
		serial_port0_select == spm_pkg::SPM_SEL_BSP |=>
			sp0_pad_out[4:0] == $past(bsp_out) && bsp_in == $past(sp0_pad_in[4:0]))
		else $error("buffered port routing wrong");

	// pin 5 clock role follows bit 15
	bsp_clock_a: assert property (
		@(posedge core_clk) disable iff (reset)
		serial_port0_select == spm_pkg::SPM_SEL_BSP |=>
			($past(bsp_clk_sel) ?
				(sp0_pad_oe_n[5] && bsp_src_clk_in == $past(sp0_pad_in[5])
				&& !bsp_rx_clk_in) :
				(sp0_pad_out[5] == $past(bsp_rx_clk_out)
				&& bsp_rx_clk_in == $past(sp0_pad_in[5]) && !bsp_src_clk_in)))
		else $error("pin 5 clock role wrong");

	// serial port 0 pull-downs follow the written inhibit bits
	pull_one_a: assert property (
		@(posedge core_clk) disable iff (reset)
		pull_one_write_s |=> sp0_pulldown_en == ~$past(reg_wdata[5:0]))
		else $error("serial port pull-down not following inhibit");

	// all address pins on the memory address, always driven
	addr_route_a: assert property (
		@(posedge core_clk) disable iff (reset)
		pads_live_q && addr_pin_select == 6'h00 |=>
			addr_pad_out == $past(ext_mem_addr_line) && addr_pad_oe_n == 6'h00
			&& gp_hi_in == 6'h00)
		else $error("address pins not on memory address");

	// only address 15 moved: it lands on gp 21, the rest stay put
	addr_order_a: assert property (
		@(posedge core_clk) disable iff (reset)
		addr_pin_select == 6'h01 |=>
			addr_pad_out[0] == $past(gp_hi_out[0])
			&& addr_pad_out[5:1] == $past(ext_mem_addr_line[5:1])
			&& gp_hi_in[0] == $past(addr_pad_in[0]))
		else $error("address 15 to gp 21 mapping wrong");

	// address pull-downs follow their register, whatever the select
	pull_two_a: assert property (
		@(posedge core_clk) disable iff (reset)
		pull_two_write_s |=> addr_pulldown_en == ~$past(reg_wdata[5:0]))
		else $error("address pull-down not following inhibit");

	// unrouted peripherals see low inputs
	idle_inputs_a: assert property (
		@(posedge core_clk) disable iff (reset)
		serial_port0_select == spm_pkg::SPM_SEL_GP |=>
			card_in == 6'h00 && audio_in == 4'h0 && bsp_in == 5'h00
			&& !bsp_rx_clk_in && !bsp_src_clk_in)
		else $error("unrouted peripheral sees pad input");

	// card port holds the pins from reset onward, enables and inputs too
	card_mode_a: assert property (
		@(posedge core_clk) disable iff (reset)
		pads_live_q && serial_port0_select == spm_pkg::SPM_SEL_CARD |=>
			sp0_pad_out == $past(card_out) && sp0_pad_oe_n == $past(card_oe_n)
			&& card_in == $past(sp0_pad_in))
		else $error("card port mode routing wrong");

	// in card mode every other serial port 0 function sees low inputs
	card_idle_a: assert property (
		@(posedge core_clk) disable iff (reset)
		serial_port0_select == spm_pkg::SPM_SEL_CARD |=>
			audio_in == 4'h0 && gp_lo_in == 6'h00 && bsp_in == 5'h00
			&& !bsp_rx_clk_in && !bsp_src_clk_in)
		else $error("card mode leaks pad input");

	// audio mode enables, with card and buffered ports cut off
	audio_enable_a: assert property (
		@(posedge core_clk) disable iff (reset)
		serial_port0_select == spm_pkg::SPM_SEL_AUDIO |=>
			sp0_pad_oe_n == {$past(gp_lo_oe_n[5:4]), $past(audio_oe_n)}
			&& card_in == 6'h00 && bsp_in == 5'h00)
		else $error("audio mode enables wrong");

	// buffered port enables on pins 0 to 4, other ports cut off
	bsp_enable_a: assert property (
		@(posedge core_clk) disable iff (reset)
		serial_port0_select == spm_pkg::SPM_SEL_BSP |=>
			sp0_pad_oe_n[4:0] == $past(bsp_oe_n)
			&& card_in == 6'h00 && audio_in == 4'h0 && gp_lo_in == 6'h00)
		else $error("buffered port enables wrong");

	// as receive clock, pin 5 is two-way under the port's own enable
	rx_clock_drive_a: assert property (
		@(posedge core_clk) disable iff (reset)
		serial_port0_select == spm_pkg::SPM_SEL_BSP && !bsp_clk_sel |=>
			sp0_pad_oe_n[5] == $past(bsp_rx_clk_oe_n))
		else $error("receive clock pin enable wrong");

	// a pin moved to general purpose takes its enable and feeds its input
	addr_gp_a: assert property (
		@(posedge core_clk) disable iff (reset)
		addr_pin_select != 6'h00 |=>
			addr_pad_oe_n == ($past(gp_hi_oe_n) & $past(addr_pin_select))
			&& gp_hi_in == ($past(addr_pad_in) & $past(addr_pin_select)))
		else $error("address pin general purpose path wrong");

	// serial port pull-downs move only on a write to their own register
	pull_one_hold_a: assert property (
		@(posedge core_clk) disable iff (reset)
		!(reg_wr && reg_addr == spm_pkg::PULL_INHIBIT_ONE_ADDR) |=>
			$stable(sp0_pulldown_en))
		else $error("serial port pull-down changed without a write");

	// address pull-downs ignore select writes: only their register counts
	pull_two_hold_a: assert property (
		@(posedge core_clk) disable iff (reset)
		!(reg_wr && reg_addr == spm_pkg::PULL_INHIBIT_TWO_ADDR) |=>
			$stable(addr_pulldown_en))
		else $error("address pull-down changed without a write");

	// software must see the selects it wrote, one cycle after the strobe
	read_back_a: assert property (
		@(posedge core_clk) disable iff (reset)
		sel_read_s |=> reg_rdata == $past(ext_bus_select_reg))
		else $error("select register read back wrong");
endmodule : spm_pin_mux
`default_nettype wire

/* rtl/spm_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module spm_regs (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic [15:0] ext_bus_select_reg,
	output logic [15:0] pull_inhibit_reg_one,
	output logic [15:0] pull_inhibit_reg_two
);
	// external bus select register: all mux selects live here
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ext_bus_select_reg <= spm_pkg::EXT_BUS_SELECT_RESET;
		end else if (reg_wr && reg_addr == spm_pkg::EXT_BUS_SELECT_ADDR) begin
			ext_bus_select_reg <= reg_wdata;
		end
	end

	// pull inhibit registers; upper bits kept for other pin groups
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pull_inhibit_reg_one <= spm_pkg::PULL_INHIBIT_RESET;
			pull_inhibit_reg_two <= spm_pkg::PULL_INHIBIT_RESET;
		end else if (reg_wr && reg_addr == spm_pkg::PULL_INHIBIT_ONE_ADDR) begin
			pull_inhibit_reg_one <= reg_wdata;
		end else if (reg_wr && reg_addr == spm_pkg::PULL_INHIBIT_TWO_ADDR) begin
			pull_inhibit_reg_two <= reg_wdata;
		end
	end

	// read data valid only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= spm_pkg::READ_IDLE;
		end else if (!reg_rd) begin
			reg_rdata <= spm_pkg::READ_IDLE;
		end else if (reg_addr == spm_pkg::EXT_BUS_SELECT_ADDR) begin
			reg_rdata <= ext_bus_select_reg;
		end else if (reg_addr == spm_pkg::PULL_INHIBIT_ONE_ADDR) begin
			reg_rdata <= pull_inhibit_reg_one;
		end else if (reg_addr == spm_pkg::PULL_INHIBIT_TWO_ADDR) begin
			reg_rdata <= pull_inhibit_reg_two;
		end else begin
			reg_rdata <= spm_pkg::READ_IDLE;
		end
	end
endmodule : spm_regs
`default_nettype wire

/* rtl/spm_sp0_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module spm_sp0_mux (
	input wire spm_pkg::spm_sp0_sel_t sel,
	input wire logic bsp_clk_sel,
	input wire logic [5:0] pad_in,
	input wire logic [5:0] card_out,
	input wire logic [5:0] card_oe_n,
	input wire logic [3:0] audio_out,
	input wire logic [3:0] audio_oe_n,
	input wire logic [5:0] gp_out,
	input wire logic [5:0] gp_oe_n,
	input wire logic [4:0] bsp_out,
	input wire logic [4:0] bsp_oe_n,
	input wire logic bsp_rx_clk_out,
	input wire logic bsp_rx_clk_oe_n,
	output logic [5:0] pad_out,
	output logic [5:0] pad_oe_n,
	output logic [5:0] card_in,
	output logic [3:0] audio_in,
	output logic [5:0] gp_in,
	output logic [4:0] bsp_in,
	output logic bsp_rx_clk_in,
	output logic bsp_src_clk_in
);
	// unrouted inputs default low and pads default undriven
	always_comb begin
		pad_out = 6'h00;
		pad_oe_n = 6'h3f;
		card_in = 6'h00;
		audio_in = 4'h0;
		gp_in = 6'h00;
		bsp_in = 5'h00;
		bsp_rx_clk_in = 1'b0;
		bsp_src_clk_in = 1'b0;
		case (sel)
			spm_pkg::SPM_SEL_CARD: begin
				pad_out = card_out;
				pad_oe_n = card_oe_n;
				card_in = pad_in;
			end
			spm_pkg::SPM_SEL_AUDIO: begin
				pad_out = {gp_out[5:4], audio_out};
				pad_oe_n = {gp_oe_n[5:4], audio_oe_n};
				audio_in = pad_in[3:0];
				gp_in = {pad_in[5:4], 4'h0};
			end
			spm_pkg::SPM_SEL_GP: begin
				pad_out = gp_out;
				pad_oe_n = gp_oe_n;
				gp_in = pad_in;
			end
			default: begin
				// source clock is input only, so pin 5 stays undriven then
				pad_out[4:0] = bsp_out;
				pad_oe_n[4:0] = bsp_oe_n;
				bsp_in = pad_in[4:0];
				if (bsp_clk_sel) begin
					bsp_src_clk_in = pad_in[5];
				end else begin
					pad_out[5] = bsp_rx_clk_out;
					pad_oe_n[5] = bsp_rx_clk_oe_n;
					bsp_rx_clk_in = pad_in[5];
				end
			end
		endcase
	end
endmodule : spm_sp0_mux
`default_nettype wire

/* verification/spm_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none
// board side of six pads: device drive wins, then a board driver, then the pull
module spm_pad_model (
	input wire logic core_clk,
	input wire logic [5:0] pad_out,
	input wire logic [5:0] pad_oe_n,
	input wire logic [5:0] pulldown_en,
	input wire logic [5:0] ext_en,
	input wire logic [5:0] ext_val,
	output logic [5:0] pad_in
);
	logic noise_q = 1'b0;

	// a floating pin must not look stable, so it flips every cycle
	always_ff @(posedge core_clk) begin
		noise_q <= ~noise_q;
	end

	// resolve each pad from every party's enable
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
			else if (ext_en[i]) pad_in[i] = ext_val[i];
			else if (pulldown_en[i]) pad_in[i] = 1'b0;
			else pad_in[i] = noise_q;
		end
	end
endmodule : spm_pad_model
`default_nettype wire

/* verification/spm_pin_mux_test.sv */
`timescale 1ns/1ps
`default_nettype none
module spm_pin_mux_test;
	localparam logic [15:0] SEL_A = spm_pkg::EXT_BUS_SELECT_ADDR;
	localparam logic [15:0] PI1_A = spm_pkg::PULL_INHIBIT_ONE_ADDR;
	localparam logic [15:0] PI2_A = spm_pkg::PULL_INHIBIT_TWO_ADDR;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [5:0] sp0_pad_in, sp0_pad_out, sp0_pad_oe_n, sp0_pulldown_en;
	logic [5:0] addr_pad_in, addr_pad_out, addr_pad_oe_n, addr_pulldown_en;
	logic [5:0] card_out = 6'h2d;
	logic [5:0] card_oe_n = 6'h12;
	logic [5:0] card_in;
	logic [3:0] audio_out = 4'h9;
	logic [3:0] audio_oe_n = 4'h4;
	logic [3:0] audio_in;
	logic [4:0] bsp_out = 5'h16;
	logic [4:0] bsp_oe_n = 5'h09;
	logic [4:0] bsp_in;
	logic bsp_rx_clk_out = 1'b1;
	logic bsp_rx_clk_oe_n = 1'b0;
	logic bsp_rx_clk_in, bsp_src_clk_in;
	logic [5:0] gp_lo_out = 6'h1b;
	logic [5:0] gp_lo_oe_n = 6'h24;
	logic [5:0] gp_lo_in;
	logic [5:0] gp_hi_out = 6'h33;
	logic [5:0] gp_hi_oe_n = 6'h0c;
	logic [5:0] gp_hi_in;
	logic [5:0] ext_mem_addr_line = 6'h25;
	logic [5:0] board_en = 6'h3f;
	int bad_count = 0;
	int tests_run = 0;

	spm_pin_mux spm_pin_mux_inst (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .sp0_pad_in, .sp0_pad_out, .sp0_pad_oe_n, .sp0_pulldown_en, .addr_pad_in,
		.addr_pad_out, .addr_pad_oe_n, .addr_pulldown_en, .card_out, .card_oe_n, .card_in,
		.audio_out, .audio_oe_n, .audio_in, .bsp_out, .bsp_oe_n, .bsp_in, .bsp_rx_clk_out,
		.bsp_rx_clk_oe_n, .bsp_rx_clk_in, .bsp_src_clk_in, .gp_lo_out, .gp_lo_oe_n, .gp_lo_in,
		.gp_hi_out, .gp_hi_oe_n, .gp_hi_in, .ext_mem_addr_line);

	// board drives every released pad with a known pattern
	spm_pad_model sp0_pads (.core_clk, .pad_out(sp0_pad_out), .pad_oe_n(sp0_pad_oe_n),
		.pulldown_en(sp0_pulldown_en), .ext_en(board_en), .ext_val(6'h35), .pad_in(sp0_pad_in));
	spm_pad_model addr_pads (.core_clk, .pad_out(addr_pad_out), .pad_oe_n(addr_pad_oe_n),
		.pulldown_en(addr_pulldown_en), .ext_en(board_en), .ext_val(6'h1e), .pad_in(addr_pad_in));

	initial begin
		forever #2 core_clk = ~core_clk;
	end

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(what, reg_rdata, exp);
	endtask : rd

	// peripherals either drive a mixed pattern or release every pin
	task automatic set_oe(input logic rel);
		@(posedge core_clk);
		card_oe_n <= rel ? 6'h3f : 6'h12;
		audio_oe_n <= rel ? 4'hf : 4'h4;
		gp_lo_oe_n <= rel ? 6'h3f : 6'h24;
		bsp_oe_n <= rel ? 5'h1f : 5'h09;
		bsp_rx_clk_oe_n <= rel;
		gp_hi_oe_n <= rel ? 6'h3f : 6'h0c;
		repeat (3) @(posedge core_clk);
		#1;
	endtask : set_oe

	// hang guard, far beyond the roughly one hundred cycles the sequence needs
	initial begin
		repeat (4000) @(posedge core_clk);
		bad_count++;
		print_verdict();
	end

	initial begin
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 chk("reset drive", 16'(sp0_pad_out), 16'(card_out));
		chk("reset pulls", {4'h0, sp0_pulldown_en, addr_pulldown_en}, 16'h0fff);
		rd(SEL_A, 16'h0000, "select reset");
		@(posedge core_clk);
		#1 chk("rdata idle", reg_rdata, 16'h0000);
		wr(PI1_A, 16'hffd5);
		wr(PI2_A, 16'h802a);
		// unmapped write must not alias onto the pull registers
		wr(16'h1c19, 16'hffff);
		rd(16'h1c19, 16'h0000, "unmapped read");
		rd(PI1_A, 16'hffd5, "pull one");
		rd(PI2_A, 16'h802a, "pull two");
		chk("sp0 pulls", 16'(sp0_pulldown_en), 16'h002a);
		for (int m = 0; m < 5; m++) begin
			logic [1:0] sel;
			logic b15;
			logic [5:0] asel, eo, en, mask;
			logic [15:0] d;
			sel = (m == 4) ? 2'd3 : m[1:0];
			b15 = (m == 4);
			asel = (m == 4) ? 6'h01 : m[0] ? 6'h29 : 6'h16;
			d = (16'(sel) << spm_pkg::SP0_SEL_LSB) | (16'(b15) << spm_pkg::BSP_CLK_SEL_BIT);
			d = d | (16'(asel) << spm_pkg::ADDR_SEL_LSB);
			wr(SEL_A, d);
			rd(SEL_A, d, "select readback");
			// peripherals restart only after the new routing is in place
			set_oe(1'b0);
			case (sel)
				2'd0: begin
					eo = card_out;
					en = card_oe_n;
				end
				2'd1: begin
					eo = {gp_lo_out[5:4], audio_out};
					en = {gp_lo_oe_n[5:4], audio_oe_n};
				end
				2'd2: begin
					eo = gp_lo_out;
					en = gp_lo_oe_n;
				end
				default: begin
					eo = {bsp_rx_clk_out, bsp_out};
					en = {bsp_rx_clk_oe_n | b15, bsp_oe_n};
				end
			endcase
			// an undriven source-clock pad has no defined drive value
			mask = b15 ? 6'h1f : 6'h3f;
			chk("sp0 drive", 16'(sp0_pad_out & mask), 16'(eo & mask));
			chk("sp0 enable", 16'(sp0_pad_oe_n), 16'(en));
			chk("addr drive", 16'(addr_pad_out), 16'((asel & gp_hi_out) | (~asel & ext_mem_addr_line)));
			chk("addr enable", 16'(addr_pad_oe_n), 16'(asel & gp_hi_oe_n));
			chk("addr pulls", 16'(addr_pulldown_en), 16'h0015);
			set_oe(1'b1);
			chk("sp0 ins a", {card_in, audio_in, gp_lo_in}, {(sel == 0) ? 6'h35 : 6'h00,
				(sel == 1) ? 4'h5 : 4'h0, (sel == 2) ? 6'h35 : (sel == 1) ? 6'h30 : 6'h00});
			chk("sp0 ins b", {3'h0, bsp_in, bsp_rx_clk_in, bsp_src_clk_in, gp_hi_in},
				{3'h0, (sel == 3) ? 5'h15 : 5'h00, sel == 3 && !b15, sel == 3 && b15,
				asel & 6'h1e});
		end
		// board lets go: enabled pull-downs must hold released pins low
		@(posedge core_clk);
		board_en <= 6'h00;
		wr(PI1_A, 16'h0000);
		set_oe(1'b1);
		chk("pulled ins", {4'h0, bsp_in, bsp_src_clk_in, gp_hi_in}, 16'h0000);
		print_verdict();
	end
endmodule : spm_pin_mux_test
`default_nettype wire
